// file: logic/cafr_top.sv
// channel adaptation: raw source/sink and packet framing source
//
// Overview of operation
// - raw source passes data without framing
// - idle request replaces data with idle marker
// - raw sink flags idle markers to application
// - packet source tracks transmit buffer fill level
// - empty buffer in data slot sends idle
// - crc-32 computed over packet data words
// - slot checksum placed in header and trailer
// - state machine flags header and trailer slots
// - header holds constants, id, length, priority, C/T
// - trailer holds constants, crc, checksum, C bit
// - output mux picks header, trailer or data
module cafr_top import cafr_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF, // transmit buffer words
  parameter int SLOT_DIV = SLOT_DIV_DEF      // clocks per slot
) (
  input wire logic clk_sys,                // 100 MHz system clock
  input wire logic arst_n,                 // async reset, active low
  // raw source
  input wire cafr_chword_type raw_src_word, // application word
  input wire logic raw_src_valid,          // application word strobe
  input wire logic raw_idle_insert_request, // replace word by idle
  input wire logic raw_src_psi,            // application protection status
  input wire logic raw_server_fail_in,     // application fail
  output cafr_chword_type raw_ch_word,     // word toward channel
  output logic raw_ch_valid,               // channel word strobe
  output logic raw_ch_psi,                 // protection status out
  output logic raw_trail_fail_out,         // fail toward channel
  // raw sink
  input wire cafr_chword_type snk_ch_word, // word from channel
  input wire logic snk_ch_valid,           // channel word strobe
  input wire logic snk_ch_psi,             // channel protection status
  input wire logic snk_ch_trail_fail,      // channel trail fail
  output cafr_chword_type snk_app_word,    // word to application
  output logic snk_app_valid,              // application word strobe
  output logic snk_app_psi,                // protection status out
  output logic idle_detect_ind,            // current word is idle
  output logic snk_server_fail_out,        // fail to application
  // packet source
  input wire cafr_pktword_type pkt_in,     // packet word with header info
  input wire logic pkt_in_valid,           // packet word offered
  output logic pkt_in_ready,               // buffer accepts word
  input wire logic pkt_idle_insert_request, // replace slot by idle
  input wire logic server_fail_in,         // application fail
  output cafr_chword_type pkt_ch_word,     // framed word toward channel
  output logic pkt_ch_valid,               // one pulse per slot
  output logic header_slot_active,         // header in this slot
  output logic trailer_slot_active,        // trailer in this slot
  output logic protection_status_ind,      // always low
  output logic trail_fail_out,             // fail toward channel
  output logic [31:0] packet_crc_value,    // crc of last packet
  output logic [7:0] slot_word_checksum,   // low byte of slot word, checksum in header/trailer
  output logic [$clog2(FIFO_DEPTH+1)-1:0] fill_level, // buffer level
  output logic neg_just_pulse,             // idle sent for empty buffer
  // register port
  input wire logic [REG_AW-1:0] reg_addr,  // register byte address
  input wire logic [REG_DW-1:0] reg_wdata, // write data
  input wire logic reg_wr,                 // write strobe
  input wire logic reg_rd,                 // read strobe
  output logic [REG_DW-1:0] reg_rdata      // read data, next cycle
);
  localparam int FW = $bits(cafr_pktword_type);
  localparam int LW = $clog2(FIFO_DEPTH+1);
  localparam int DW = $clog2(SLOT_DIV);

  // ----------------------------------------------------------------
  // raw null-mapping source and sink
  // ----------------------------------------------------------------
  cafr_chword_type raw_ch_word_ff;         // registered channel word
  logic raw_ch_valid_ff;
  logic raw_ch_psi_ff;
  logic raw_trail_fail_ff;
  cafr_chword_type snk_app_word_ff;        // registered app word
  logic snk_app_valid_ff;
  logic snk_app_psi_ff;
  logic idle_detect_ff;
  logic snk_fail_ff;
  // idle marker overrides the word, else straight through
  wire cafr_chword_type nxt_raw_word =
    raw_idle_insert_request ? IDLE_WORD : raw_src_word;
  wire nxt_idle_det = (snk_ch_word == IDLE_WORD);

  // raw paths: one register stage, no framing
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      raw_ch_word_ff <= '0;
      raw_ch_valid_ff <= 1'b0;
      raw_ch_psi_ff <= 1'b0;
      raw_trail_fail_ff <= 1'b0;
      snk_app_word_ff <= '0;
      snk_app_valid_ff <= 1'b0;
      snk_app_psi_ff <= 1'b0;
      idle_detect_ff <= 1'b0;
      snk_fail_ff <= 1'b0;
    end else begin
      if (raw_src_valid) raw_ch_word_ff <= nxt_raw_word;
      raw_ch_valid_ff <= raw_src_valid;
      raw_ch_psi_ff <= raw_src_psi;
      raw_trail_fail_ff <= raw_server_fail_in;
      if (snk_ch_valid) begin
        snk_app_word_ff <= snk_ch_word;
        idle_detect_ff <= nxt_idle_det;
      end
      snk_app_valid_ff <= snk_ch_valid;
      snk_app_psi_ff <= snk_ch_psi;
      snk_fail_ff <= snk_ch_trail_fail;
    end
  end

  // ----------------------------------------------------------------
  // slot timing and transmit buffer
  // ----------------------------------------------------------------
  logic [DW-1:0] div_ff;                   // slot divider
  wire slot_tick = (div_ff == DW'(SLOT_DIV-1));
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) div_ff <= '0;
    else div_ff <= slot_tick ? '0 : DW'(div_ff + 1'b1);
  end

  cafr_pktword_type head;                  // oldest buffered word
  logic head_valid;
  logic pop;
  logic [LW-1:0] fifo_count;
  logic [FW-1:0] head_bits;
  assign head = cafr_pktword_type'(head_bits);

  cafr_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_data(FW'(pkt_in)),
    .in_valid(pkt_in_valid),
    .in_ready(pkt_in_ready),
    .out_data(head_bits),
    .out_valid(head_valid),
    .out_ready(pop),
    .count(fifo_count)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic ctrl_en_ff;                        // framer enable
  logic [31:0] just_cnt_ff;                // negative justifications
  logic [31:0] pkt_cnt_ff;                 // packets framed
  logic [REG_DW-1:0] rdata_ff;
  wire sel_ctrl = (reg_addr == REG_CTRL);
  wire sel_fill = (reg_addr == REG_FILL);
  wire sel_just = (reg_addr == REG_JUST);
  wire sel_pkts = (reg_addr == REG_PKTS);
  logic [REG_DW-1:0] rd_mux;
  // unmapped addresses read as zero
  assign rd_mux = sel_ctrl ? {31'h0, ctrl_en_ff} :
                  sel_fill ? REG_DW'(fifo_count) :
                  sel_just ? just_cnt_ff :
                  sel_pkts ? pkt_cnt_ff : 32'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_ff <= CTRL_EN_RST;
      rdata_ff <= '0;
    end else begin
      if (reg_wr && sel_ctrl) ctrl_en_ff <= reg_wdata[CTRL_EN_BIT];
      if (reg_rd) rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // packet framing state machine
  // ----------------------------------------------------------------
  cafr_txstate_type st_ff;
  cafr_txstate_type nxt_st;
  logic [31:0] crc_ff;                     // running crc of packet
  logic [31:0] crc_step;
  logic [31:0] crc_out_ff;                 // crc carried in trailer
  cafr_chword_type pkt_word_ff;
  logic pkt_valid_ff, hdr_ff, trl_ff, just_ff;
  logic [7:0] csum_ff;
  logic [LW-1:0] fill_ff;
  logic fail_ff;

  cafr_crc32 u_crc (
    .crc_in(crc_ff),
    .data_in(head.data),
    .crc_out(crc_step)
  );

  // control word bodies, checksum field still empty
  wire [63:0] hdr_body = {1'b1, 1'b1, HDR_CONST, head.cmi, head.len,
                          head.pri, 12'h000, 8'h00};
  wire [31:0] crc_final = ~crc_ff;
  wire [63:0] trl_body = {1'b1, 1'b0, TRL_CONST, 16'h0000, crc_final,
                          8'h00};
  wire [63:0] hdr_w = {hdr_body[63:8], cafr_csum(hdr_body)};
  wire [63:0] trl_w = {trl_body[63:8], cafr_csum(trl_body)};

  wire go = slot_tick && !pkt_idle_insert_request;
  wire start_pkt = (st_ff == ST_IDLE) && ctrl_en_ff && head_valid &&
                   head.sop;
  wire stray = (st_ff == ST_IDLE) && head_valid && !head.sop;
  wire send_data = (st_ff == ST_DATA) && head_valid;
  wire nxt_hdr = go && start_pkt;
  wire nxt_trl = go && (st_ff == ST_TRAIL);
  wire nxt_just = go && (st_ff == ST_DATA) && !head_valid;
  assign pop = go && (send_data || stray);
  // stray words outside a packet are dropped, never framed

  // output selection: header, trailer, data, else idle marker
  wire cafr_chword_type nxt_word =
    nxt_hdr ? '{special: 1'b0, data: hdr_w} :
    nxt_trl ? '{special: 1'b0, data: trl_w} :
    (go && send_data) ? '{special: 1'b0, data: head.data} :
    IDLE_WORD;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (nxt_hdr) nxt_st = ST_DATA;
      ST_DATA: if (go && send_data && head.eop) nxt_st = ST_TRAIL;
      ST_TRAIL: if (go) nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  // state, crc and slot outputs move only on slot ticks
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_IDLE;
      crc_ff <= CRC_INIT;
      crc_out_ff <= '0;
      pkt_word_ff <= '0;
      hdr_ff <= 1'b0;
      trl_ff <= 1'b0;
      csum_ff <= '0;
    end else if (slot_tick) begin
      st_ff <= nxt_st;
      if (nxt_hdr) crc_ff <= CRC_INIT;
      else if (go && send_data) crc_ff <= crc_step;
      if (nxt_trl) crc_out_ff <= crc_final;
      pkt_word_ff <= nxt_word;
      hdr_ff <= nxt_hdr;
      trl_ff <= nxt_trl;
      csum_ff <= nxt_word.data[7:0];
    end
  end

  // per-slot strobes, fill tracking, counters and fail forwarding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pkt_valid_ff <= 1'b0;
      just_ff <= 1'b0;
      fill_ff <= '0;
      fail_ff <= 1'b0;
      just_cnt_ff <= '0;
      pkt_cnt_ff <= '0;
    end else begin
      pkt_valid_ff <= slot_tick;
      just_ff <= nxt_just;
      fill_ff <= fifo_count;
      fail_ff <= server_fail_in;
      if (nxt_just) just_cnt_ff <= just_cnt_ff + 32'h1;
      if (nxt_trl) pkt_cnt_ff <= pkt_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign raw_ch_word = raw_ch_word_ff;
  assign raw_ch_valid = raw_ch_valid_ff;
  assign raw_ch_psi = raw_ch_psi_ff;
  assign raw_trail_fail_out = raw_trail_fail_ff;
  assign snk_app_word = snk_app_word_ff;
  assign snk_app_valid = snk_app_valid_ff;
  assign snk_app_psi = snk_app_psi_ff;
  assign idle_detect_ind = idle_detect_ff;
  assign snk_server_fail_out = snk_fail_ff;
  assign pkt_ch_word = pkt_word_ff;
  assign pkt_ch_valid = pkt_valid_ff;
  assign header_slot_active = hdr_ff;
  assign trailer_slot_active = trl_ff;
  assign protection_status_ind = 1'b0;
  assign trail_fail_out = fail_ff;
  assign packet_crc_value = crc_out_ff;
  assign slot_word_checksum = csum_ff;
  assign fill_level = fill_ff;
  assign neg_just_pulse = just_ff;
  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  raw_pass_a: assert property (raw_src_valid && !raw_idle_insert_request
    |=> raw_ch_word == $past(raw_src_word))
    else $error("raw word not passed through");
  raw_idle_a: assert property (raw_src_valid && raw_idle_insert_request
    |=> raw_ch_word == IDLE_WORD)
    else $error("raw idle marker missing");
  pkt_idle_a: assert property (slot_tick && pkt_idle_insert_request
    |=> pkt_ch_word == IDLE_WORD && !header_slot_active)
    else $error("packet idle marker missing");
  idle_det_a: assert property (snk_ch_valid
    |=> idle_detect_ind == ($past(snk_ch_word) == IDLE_WORD))
    else $error("idle detect wrong");
  fill_track_a: assert property ($past(arst_n) |->
    fill_level == $past(fifo_count))
    else $error("fill level stale");
  empty_just_a: assert property (go && st_ff == ST_DATA && !head_valid
    |=> neg_just_pulse && pkt_ch_word == IDLE_WORD)
    else $error("no idle for empty buffer");
  trl_crc_a: assert property (trailer_slot_active
    |-> pkt_ch_word.data[39:8] == packet_crc_value)
    else $error("trailer crc mismatch");
  hdr_csum_a: assert property (header_slot_active || trailer_slot_active
    |-> slot_word_checksum == cafr_csum(pkt_ch_word.data))
    else $error("slot checksum wrong");
  slot_excl_a: assert property (!(header_slot_active &&
    trailer_slot_active))
    else $error("header and trailer together");
  hdr_bits_a: assert property (header_slot_active |-> pkt_ch_word.data[63]
    && pkt_ch_word.data[62] && !pkt_ch_word.special)
    else $error("header C/T bits wrong");
  trl_bits_a: assert property (trailer_slot_active
    |-> pkt_ch_word.data[63] && !pkt_ch_word.data[62])
    else $error("trailer C bit wrong");
  data_mux_a: assert property (go && send_data
    |=> pkt_ch_word.data == $past(head.data))
    else $error("data word not carried");
  fail_fwd_a: assert property ($past(arst_n) |->
    trail_fail_out == $past(server_fail_in) && !protection_status_ind)
    else $error("fail or status wrong");
  snk_fail_a: assert property ($past(arst_n) |->
    snk_server_fail_out == $past(snk_ch_trail_fail))
    else $error("sink fail not forwarded");

  hdr_seen_c: cover property (header_slot_active);
  trl_seen_c: cover property (trailer_slot_active);
  just_seen_c: cover property (neg_just_pulse);
  full_seen_c: cover property (!pkt_in_ready);

endmodule // cafr_top

// file: logic/cafr_pkg.sv
// shared constants, word layouts and helpers of the channel adaptation framer
package cafr_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int WORD_W = 64;              // channel slot word payload
  localparam int FIFO_DEPTH_DEF = 16;      // transmit buffer words
  localparam int SLOT_DIV_DEF = 4;         // clocks per channel slot
  localparam int REG_AW = 8;               // register address width
  localparam int REG_DW = 32;              // register data width

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // control
  localparam logic [7:0] REG_FILL = 8'h04; // buffer fill level
  localparam logic [7:0] REG_JUST = 8'h08; // negative justifications
  localparam logic [7:0] REG_PKTS = 8'h0c; // packets framed
  localparam int CTRL_EN_BIT = 0;          // packet framer enable
  localparam logic CTRL_EN_RST = 1'b1;     // framer enabled after reset

  // ----------------------------------------------------------------
  // idle special marker and header / trailer layouts
  // ----------------------------------------------------------------
  localparam logic [63:0] IDLE_CODE = 64'h0000_0000_0000_0001;
  localparam int C_BIT = 63;               // control word flag
  localparam int T_BIT = 62;               // header flag
  localparam int CONST_HI = 61;
  localparam int CONST_LO = 56;
  localparam logic [5:0] HDR_CONST = 6'h2a; // fixed header pattern
  localparam logic [5:0] TRL_CONST = 6'h15; // fixed trailer pattern
  localparam int CMI_LO = 40;              // [55:40] channel_mux_id
  localparam int LEN_LO = 24;              // [39:24] length in octets
  localparam int PRI_LO = 20;              // [23:20] priority
  localparam int CRC_LO = 8;               // [39:8] trailer crc
  localparam int CSUM_W = 8;               // [7:0] slot word checksum
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY = 32'hedb8_8320; // reflected form

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic special;                         // special marker flag
    logic [WORD_W-1:0] data;               // slot word
  } cafr_chword_type;

  typedef struct packed {
    logic sop;                             // first data word of packet
    logic eop;                             // last data word of packet
    logic [15:0] cmi;                      // channel_mux_id
    logic [15:0] len;                      // packet_length_octets
    logic [3:0] pri;                       // packet_priority
    logic [WORD_W-1:0] data;               // payload word
  } cafr_pktword_type;

  localparam cafr_chword_type IDLE_WORD = '{special: 1'b1, data: IDLE_CODE};

  typedef enum logic [1:0] {
    ST_IDLE, ST_DATA, ST_TRAIL
  } cafr_txstate_type;

  // xor of the bytes above the checksum field
  function automatic logic [7:0] cafr_csum(input logic [63:0] w);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 1; i < 8; i++) begin
      acc = acc ^ w[i*8 +: 8];
    end
    return acc;
  endfunction

endpackage

// file: logic/cafr_fifo.sv
// transmit buffer: parameterised flip-flop fifo with valid/ready
module cafr_fifo #(
  parameter int W = 8,                     // word width
  parameter int DEPTH = 16                 // number of words
) (
  input wire logic clk_sys,                // system clock
  input wire logic arst_n,                 // async reset, active low
  input wire logic [W-1:0] in_data,        // word to store
  input wire logic in_valid,               // store request
  output logic in_ready,                   // room for a word
  output logic [W-1:0] out_data,           // oldest word
  output logic out_valid,                  // oldest word present
  input wire logic out_ready,              // consumer takes word
  output logic [$clog2(DEPTH+1)-1:0] count // words held
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem_ff [DEPTH];            // storage
  logic [PW-1:0] wr_ff, rd_ff;             // pointers
  logic [CW-1:0] cnt_ff;                   // fill level
  logic rdy_ff;                            // registered not-full
  wire push = in_valid && rdy_ff;
  wire pop = out_ready && (cnt_ff != '0);
  wire [CW-1:0] nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
  wire [PW-1:0] nxt_wr = (wr_ff == PW'(DEPTH-1)) ? '0 : PW'(wr_ff + 1'b1);
  wire [PW-1:0] nxt_rd = (rd_ff == PW'(DEPTH-1)) ? '0 : PW'(rd_ff + 1'b1);

  assign in_ready = rdy_ff;
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign count = cnt_ff;

  // pointers and level; ready stays registered so it never loops back
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      rdy_ff <= 1'b1;
    end else begin
      if (push) wr_ff <= nxt_wr;
      if (pop) rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      rdy_ff <= (nxt_cnt != CW'(DEPTH));
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge clk_sys) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

endmodule // cafr_fifo

// file: logic/cafr_crc32.sv
// one 64-bit step of the reflected crc-32 over a data slot word
module cafr_crc32 import cafr_pkg::*; (
  input wire logic [31:0] crc_in,          // running remainder
  input wire logic [63:0] data_in,         // slot word, lsb first
  output logic [31:0] crc_out              // remainder after word
);
  // bit-serial loop unrolled by the tool; one word per slot is ample
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 0; i < 64; i++) begin
      if (c[0] ^ data_in[i]) c = (c >> 1) ^ CRC_POLY;
      else c = c >> 1;
    end
    crc_out = c;
  end

endmodule // cafr_crc32

// file: testbench/cafr_chan_model.sv
// channel side model: carries raw source words back into the raw sink
module cafr_chan_model import cafr_pkg::*; (
  input wire cafr_chword_type tx_word, // word sent toward channel
  input wire logic tx_valid, // source word strobe
  input wire logic tx_psi, // protection status from source
  input wire logic tx_fail, // trail fail from source
  output cafr_chword_type rx_word, // word handed to sink
  output logic rx_valid, // sink word strobe
  output logic rx_psi, // protection status to sink
  output logic rx_fail // trail fail to sink
);
  timeunit 1ns;
  timeprecision 1ps;
  // plain wire channel: source outputs are registered, so no race here
  assign rx_word = tx_word;
  assign rx_valid = tx_valid;
  assign rx_psi = tx_psi;
  assign rx_fail = tx_fail;
endmodule // cafr_chan_model

// file: testbench/test_channel_app_adaptation_framer.sv
// self-checking bench of the channel adaptation framer
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_channel_app_adaptation_framer import cafr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_sys, arst_n, raw_src_valid, raw_idle_insert_request;
  cafr_chword_type raw_src_word, raw_ch_word, snk_ch_word, snk_app_word;
  cafr_chword_type pkt_ch_word; // framed slot word
  logic raw_src_psi, raw_server_fail_in, raw_ch_valid, raw_ch_psi;
  logic raw_trail_fail_out, snk_ch_valid, snk_ch_psi, snk_ch_trail_fail;
  logic snk_app_valid, snk_app_psi, idle_detect_ind, snk_server_fail_out;
  cafr_pktword_type pkt_in; // packet word offered
  logic pkt_in_valid, pkt_in_ready, pkt_idle_insert_request;
  logic server_fail_in, pkt_ch_valid, header_slot_active;
  logic trailer_slot_active, protection_status_ind, trail_fail_out;
  logic neg_just_pulse, reg_wr, reg_rd;
  logic [31:0] packet_crc_value, reg_wdata, reg_rdata, rd_val, crc;
  logic [7:0] slot_word_checksum, reg_addr;
  logic [4:0] fill_level;
  logic [63:0] ev; // expected control word
  int n_mismatch, cmp_count, cycles, n_just;
  cafr_top #(.FIFO_DEPTH(16), .SLOT_DIV(4)) u_cafr_top (.*);
  cafr_chan_model u_cafr_chan_model (.tx_word(raw_ch_word),
    .tx_valid(raw_ch_valid), .tx_psi(raw_ch_psi),
    .tx_fail(raw_trail_fail_out), .rx_word(snk_ch_word),
    .rx_valid(snk_ch_valid), .rx_psi(snk_ch_psi),
    .rx_fail(snk_ch_trail_fail));
  // ----------------------------------------------------------------
  // helpers: own checksum and crc, never the design's functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] xsum(input logic [63:0] w);
    logic [7:0] a;
    a = 8'h00;
    for (int i = 1; i < 8; i++) a ^= w[i*8 +: 8];
    return a;
  endfunction
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [63:0] d);
    for (int i = 0; i < 64; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 0);
    return c;
  endfunction
  function automatic logic [63:0] dw(input int i);
    return 64'h0123_4567_0000_0000 | 64'(i);
  endfunction
  task automatic test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // register access: one strobe cycle, read data the cycle after
  task automatic reg_rw(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // one raw word out through the channel model and back to the sink
  task automatic raw_send(input int i, input logic ii,
                          input cafr_chword_type ex);
    @(posedge clk_sys);
    raw_src_word <= '{special: 1'b0, data: dw(i)};
    raw_src_valid <= 1'b1;
    raw_idle_insert_request <= ii;
    raw_src_psi <= !ii;
    raw_server_fail_in <= !ii;
    @(posedge clk_sys);
    raw_src_valid <= 1'b0;
    @(negedge clk_sys);
    `CHK("raw_ch_word", ex, raw_ch_word)
    `CHK("raw_ch_valid", 1'b1, raw_ch_valid)
    @(negedge clk_sys);
    `CHK("snk_app_word", ex, snk_app_word)
    `CHK("snk_app_valid", 1'b1, snk_app_valid)
    `CHK("idle_detect_ind", ii, idle_detect_ind)
    `CHK("snk_fail", !ii, snk_server_fail_out)
    `CHK("snk_psi", !ii, snk_app_psi)
  endtask
  // packet words a..b kept offered until the buffer takes each one
  task automatic push(input int a, input int b, input logic e);
    @(posedge clk_sys);
    for (int i = a; i <= b; i++) begin
      pkt_in <= '{sop: i == 0, eop: e && i == b, cmi: 16'h0a5c,
                  len: 16'h0088, pri: 4'h3, data: dw(i)};
      pkt_in_valid <= 1'b1;
      do @(negedge clk_sys); while (pkt_in_ready !== 1'b1);
      @(posedge clk_sys);
    end
    pkt_in_valid <= 1'b0;
  endtask
  task automatic next_slot;
    do @(negedge clk_sys); while (pkt_ch_valid !== 1'b1);
  endtask
  // ----------------------------------------------------------------
  // clock, cycle ceiling and justification count
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (neg_just_pulse === 1'b1) n_just++;
    if (cycles >= 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {raw_src_word, raw_src_valid, raw_idle_insert_request} = '0;
    {pkt_in, pkt_in_valid, pkt_idle_insert_request} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    raw_src_psi = 1'b1;
    raw_server_fail_in = 1'b1;
    server_fail_in = 1'b1;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    raw_send(5, 1'b0, '{special: 1'b0, data: dw(5)});
    raw_send(6, 1'b1, IDLE_WORD);
    reg_rw(1'b1, REG_CTRL, 32'h0); // hold framer so the buffer fills
    push(0, 15, 1'b0);
    repeat (2) @(negedge clk_sys);
    `CHK("ready", 1'b0, pkt_in_ready)
    `CHK("fill_level", 5'd16, fill_level)
    reg_rw(1'b0, REG_FILL, 32'h0);
    `CHK("reg_fill", 32'd16, rd_val)
    reg_rw(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd_val)
    `CHK("psi", 1'b0, protection_status_ind)
    `CHK("fail", 1'b1, trail_fail_out)
    `CHK("no_just", 0, n_just)
    reg_rw(1'b1, REG_CTRL, 32'h1);
    do next_slot(); while (header_slot_active !== 1'b1);
    ev = {2'b11, HDR_CONST, 16'h0a5c, 16'h0088, 4'h3, 12'h0, 8'h00};
    ev[7:0] = xsum(ev);
    `CHK("header", ev, pkt_ch_word.data)
    `CHK("hdr_csum", ev[7:0], slot_word_checksum)
    @(posedge clk_sys);
    pkt_idle_insert_request <= 1'b1;
    server_fail_in <= 1'b0;
    next_slot();
    `CHK("ins_idle", IDLE_WORD, pkt_ch_word)
    `CHK("fail_low", 1'b0, trail_fail_out)
    @(posedge clk_sys);
    pkt_idle_insert_request <= 1'b0;
    crc = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      next_slot();
      `CHK("data", {1'b0, dw(i)}, pkt_ch_word)
      `CHK("hdr_flag", 1'b0, header_slot_active)
      crc = crc_step(crc, dw(i));
    end
    next_slot();
    `CHK("empty_idle", IDLE_WORD, pkt_ch_word)
    push(16, 16, 1'b1);
    do next_slot(); while (pkt_ch_word === IDLE_WORD);
    `CHK("last_data", {1'b0, dw(16)}, pkt_ch_word)
    crc = crc_step(crc, dw(16));
    next_slot();
    ev = {2'b10, TRL_CONST, 16'h0, ~crc, 8'h00};
    ev[7:0] = xsum(ev);
    `CHK("trl_flag", 1'b1, trailer_slot_active)
    `CHK("trailer", ev, pkt_ch_word.data)
    `CHK("crc", ~crc, packet_crc_value)
    `CHK("just_seen", 1, n_just)
    reg_rw(1'b0, REG_JUST, 32'h0);
    `CHK("reg_just", 32'h1, rd_val)
    test_done();
  end
endmodule // test_channel_app_adaptation_framer
